/* File: hdl/sds_defines.vh */
// Constants for the stacked die select logic: opcodes, die count, timing.
// Assumes inclusion by bare name from the design files only.
`ifndef SDS_DEFINES_VH
`define SDS_DEFINES_VH
`define SDS_NUM_DIES      4
`define SDS_DIE_IDENTIFIER_W      8
`define SDS_OP_DIE_SELECT 8'hC2
`define SDS_OP_RST_ENABLE 8'h66
`define SDS_OP_RST_DEVICE 8'h99
`define SDS_RESET_DIE_IDENTIFIER  8'h00
`define SDS_CLK_PERIOD_NS 25
`endif

/* File: hdl/sds_die_ctl.v */
// One die's instruction decoder: keeps the die-select and reset pair.
// Assumes bit strobes already synchronised to core_clk by the top level.
`timescale 1ns/1ps
`include "sds_defines.vh"
module sds_die_ctl #(
  parameter [7:0] DIE_IDENTIFIER = 8'h00
) (
  // Clock and reset
  input  wire       core_clk,
  input  wire       rst,
  // Frame events from the shared serial front end
  input  wire       frame_start,
  input  wire       frame_end,
  input  wire       bit_strobe,
  input  wire       bit_value,
  // Die state
  output reg        active_reg,
  output reg        soft_reset_reg
);
  reg [7:0] shift_reg;
  reg [5:0] bit_count_reg;
  reg [7:0] opcode_reg;
  reg       rst_armed_reg;
  reg       rst_armed_frame_reg;
  wire [7:0] shifted;
  assign shifted = {shift_reg[6:0], bit_value};

  always @(posedge core_clk) begin
    if (rst) begin
      shift_reg           <= 8'h00;
      bit_count_reg       <= 6'h00;
      opcode_reg          <= 8'h00;
      rst_armed_reg       <= 1'b0;
      rst_armed_frame_reg <= 1'b0;
      active_reg          <= (DIE_IDENTIFIER == `SDS_RESET_DIE_IDENTIFIER);
      soft_reset_reg      <= 1'b0;
    end else begin
      soft_reset_reg <= 1'b0;
      if (soft_reset_reg) begin
        // Return to power-up state after a software reset
        active_reg    <= (DIE_IDENTIFIER == `SDS_RESET_DIE_IDENTIFIER);
        rst_armed_reg <= 1'b0;
      end
      if (frame_start) begin
        bit_count_reg       <= 6'h00;
        rst_armed_frame_reg <= rst_armed_reg;
        rst_armed_reg       <= 1'b0;
      end else if (bit_strobe && bit_count_reg < 6'h10) begin
        shift_reg     <= shifted;
        bit_count_reg <= bit_count_reg + 6'h01;
        if (bit_count_reg == 6'h07) begin
          opcode_reg <= shifted;
          // Any die decodes these two, idle or not
          if (shifted == `SDS_OP_RST_ENABLE)
            rst_armed_reg <= 1'b1;
          if (shifted == `SDS_OP_RST_DEVICE && rst_armed_frame_reg)
            soft_reset_reg <= 1'b1;
        end
        if (bit_count_reg == 6'h0F && opcode_reg == `SDS_OP_DIE_SELECT)
          active_reg <= (shifted == DIE_IDENTIFIER);
      end
      if (frame_end && bit_count_reg != 6'h08)
        rst_armed_reg <= 1'b0;
    end
  end
endmodule

/* File: hdl/sds_stack_top.v */
// Top of the stacked die select logic: serial front end and four dies.
// Assumes serial pins come from another domain and are synchronised here.
`timescale 1ns/1ps
`include "sds_defines.vh"
module sds_stack_top (
  // Clock and reset
  input  wire       core_clk,
  input  wire       rst,
  // Serial pins
  input  wire       sclk,
  input  wire       cs_n,
  input  wire       si,
  // Serial output pin, three signals
  input  wire       so_in,
  output reg        so_out,
  output wire       so_oe,
  // Per-die data to shift out while active
  input  wire [3:0] die_data_bit,
  // Die state
  output wire [3:0] die_active,
  output wire       soft_reset
);
  reg  [1:0] sclk_sync_reg;
  reg  [1:0] cs_sync_reg;
  reg  [1:0] si_sync_reg;
  reg        sclk_prev_reg;
  reg        cs_prev_reg;
  reg        seen_fall_reg;
  wire       sclk_rise;
  wire       sclk_fall;
  wire       frame_start;
  wire       frame_end;
  wire       bit_strobe;
  wire [3:0] die_reset;
  wire       active_bit;

  always @(posedge core_clk) begin
    if (rst) begin
      sclk_sync_reg <= 2'b00;
      cs_sync_reg   <= 2'b11;
      si_sync_reg   <= 2'b00;
      sclk_prev_reg <= 1'b0;
      cs_prev_reg   <= 1'b1;
      seen_fall_reg <= 1'b0;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[0], sclk};
      cs_sync_reg   <= {cs_sync_reg[0], cs_n};
      si_sync_reg   <= {si_sync_reg[0], si};
      sclk_prev_reg <= sclk_sync_reg[1];
      cs_prev_reg   <= cs_sync_reg[1];
      if (frame_start)
        seen_fall_reg <= 1'b1;
    end
  end

  assign sclk_rise   = sclk_sync_reg[1] & ~sclk_prev_reg;
  assign sclk_fall   = ~sclk_sync_reg[1] & sclk_prev_reg;
  assign frame_start = cs_prev_reg & ~cs_sync_reg[1];
  assign frame_end   = ~cs_prev_reg & cs_sync_reg[1];
  // Bits only count inside a frame begun by a select falling edge
  assign bit_strobe  = sclk_rise & ~cs_sync_reg[1] & seen_fall_reg;

  // Die identifier for generate slot idx, cut to the identifier width
  function [7:0] die_identifier_of;
    input integer idx;
    begin
      die_identifier_of = idx[7:0];
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < `SDS_NUM_DIES; g = g + 1) begin : dies
      sds_die_ctl #(
        .DIE_IDENTIFIER (die_identifier_of(g))
      ) u_die (
        .core_clk       (core_clk),
        .rst            (rst),
        .frame_start    (frame_start),
        .frame_end      (frame_end),
        .bit_strobe     (bit_strobe),
        .bit_value      (si_sync_reg[1]),
        .active_reg     (die_active[g]),
        .soft_reset_reg (die_reset[g])
      );
    end
  endgenerate

  assign soft_reset = |die_reset;
  // Only the active die's bit reaches the pin
  assign active_bit = |(die_active & die_data_bit);

  always @(posedge core_clk) begin
    if (rst)
      so_out <= 1'b0;
    else if (sclk_fall)
      so_out <= active_bit;
  end

  // Driven only inside a frame and only with an active die
  assign so_oe = ~cs_sync_reg[1] & (|die_active);
endmodule

/* File: bench/sds_chk.sv */
// Concurrent checks on the stacked die select top, bound to its ports.
// Assumes the link clock stands low outside frames.
`timescale 1ns/1ps
module sds_chk (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rst,
  // Serial pins and die state
  input wire logic       sclk,
  input wire logic       cs_n,
  input wire logic       so_out,
  input wire logic       so_oe,
  input wire logic       soft_reset,
  input wire logic [3:0] die_active
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_one_active: assert property ($onehot0(die_active))
    else $error("dies clash");
  a_hw_reset: assert property (disable iff (1'b0) rst |=> die_active == 4'h1)
    else $error("no die zero");
  a_soft_die0: assert property (soft_reset |=> die_active == 4'h1)
    else $error("soft reset missed");
  a_pulse_once: assert property (soft_reset |=> !soft_reset)
    else $error("long pulse");
  a_idle_quiet: assert property (die_active == 4'h0 |-> !so_oe)
    else $error("idle drives");
  a_desel_float: assert property (cs_n [*4] |-> !so_oe)
    else $error("drives unselected");
  a_desel_hold: assert property (cs_n [*8] |=> $stable(die_active) && !soft_reset)
    else $error("acts unselected");
  a_so_fall: assert property ($changed(so_out) |-> !sclk)
    else $error("output off edge");
endmodule
bind sds_stack_top sds_chk i_sds_chk (.core_clk, .rst, .sclk, .cs_n, .so_out, .so_oe,
  .soft_reset, .die_active);

/* File: bench/sds_host.sv */
// Serial host model at a 200 ns link period.
// Assumes the bench calls frame and nothing else.
`timescale 1ns/1ps
module sds_host (
  // Serial pins
  output logic sclk, cs_n, si
);
  initial {sclk, cs_n, si} = 3'b010;
  // Low n bits of v, MSB first, in one frame
  task automatic frame(input logic [15:0] v, input int n);
    cs_n = 1'b0;
    #200;
    for (int i = n - 1; i >= 0; i--) begin
      si = v[i];
      #100 sclk = 1'b1;
      #100 sclk = 1'b0;
    end
    #200 si = ~si;
    cs_n = 1'b1;
    #600;
  endtask
endmodule

/* File: bench/tb_top.sv */
// Self-checking bench for the stacked die select top.
// Assumes the host model drives the serial pins.
`timescale 1ns/1ps
module tb_top;
  logic       core_clk = 0, rst = 1, so_out, so_oe, soft_reset, sclk, cs_n, si;
  logic [3:0] die_data_bit = 4'hA, die_active;
  int         err_count = 0, total_checks = 0;
  int         pulse_count = 0;
  always #12.5 core_clk = ~core_clk;
  // Counts soft reset pulses seen on the output
  always @(posedge core_clk) if (soft_reset === 1'b1) pulse_count <= pulse_count + 1;
  sds_host i_sds_host (.sclk, .cs_n, .si);
  sds_stack_top i_sds_stack_top (.core_clk, .rst, .sclk, .cs_n, .si, .so_in(1'b0), .so_out,
    .so_oe, .die_data_bit, .die_active, .soft_reset);
  task automatic cmp(input string what, input logic [3:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic sel(input logic [7:0] id, input logic [3:0] exp);
    i_sds_host.frame({8'hC2, id}, 16);
    cmp("die_active", exp, die_active);
  endtask
  // Ignored opcode; output pin looked at mid-frame
  task automatic probe(input logic oe, so);
    fork
      i_sds_host.frame(16'h0300, 16);
      begin
        #1710;
        cmp("so_oe", 4'(oe), 4'(so_oe));
        if (oe) cmp("so_out", 4'(so), 4'(so_out));
      end
    join
  endtask
  task automatic t_select_all;
    for (int id = 0; id < 4; id++) sel(8'(id), 4'h1 << id);
    probe(1'b1, die_data_bit[3]);
    cmp("die_active", 4'h8, die_active);
  endtask
  task automatic t_idle_dies;
    sel(8'h07, 4'h0);
    probe(1'b0, 1'b0);
    cmp("die_active", 4'h0, die_active);
    sel(8'h02, 4'h4);
    // Only die 2 offers a low bit, so any leak from another die shows high
    @(negedge core_clk) die_data_bit = 4'hB;
    probe(1'b1, 1'b0);
  endtask
  task automatic t_soft_reset;
    i_sds_host.frame(16'h0099, 8);
    cmp("die_active", 4'h4, die_active);
    cmp("soft_reset", 4'h0, 4'(pulse_count));
    i_sds_host.frame(16'h0066, 8);
    i_sds_host.frame(16'h0099, 8);
    cmp("die_active", 4'h1, die_active);
    cmp("soft_reset", 4'h1, 4'(pulse_count));
  endtask
  task automatic t_hw_reset;
    sel(8'h03, 4'h8);
    @(negedge core_clk);
    rst = 1'b1;
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    cmp("die_active", 4'h1, die_active);
    cmp("so_out", 4'h0, 4'(so_out));
  endtask
  initial begin
    repeat (5) @(negedge core_clk);
    rst = 1'b0;
    #100;
    cmp("die_active", 4'h1, die_active);
    t_select_all;
    t_idle_dies;
    t_soft_reset;
    t_hw_reset;
    complete_run;
  end
  initial begin
    #500000;
    err_count++;
    complete_run;
  end
endmodule
